/* File: gms_defines.svh */
// Contract
// - cursor starts on day, arrows move lines
// - enter selects first digit, digits overwrite, advance
// - right and left arrows move between digits
// - year four digits, others two digits
// - second enter commits field, back to line
// - exit on digit discards edit
// - exit at line level goes to overview
// - three minutes without enter or exit goes to overview
// - no start before overview, protection always active
// - power-up enters stop mode, stop lamp lit
// - stop mode reports events, ignores auto starts
// - stop button stops engine at once, message
// - water heater off in stop mode
// - manual only from stop or auto
// - start press starts engine in manual mode
// - auto from stop, manual, trial; message
// - auto mode follows start input edges
// - auto mode drives changeover switch itself
// - trial only from auto with inputs idle
// - first trial press pending, second confirms
// - pending trial reverts to auto after two minutes
// - trial: no changeover, countdown, stop, back auto
// - start input during trial goes to auto
`ifndef GMS_DEFINES_SVH
`define GMS_DEFINES_SVH
`define GMS_CLK_HZ        125000000
`define GMS_SEC_CYC       (`GMS_CLK_HZ)
`define GMS_MSG_S         2
`define GMS_IDLE_S        180
`define GMS_PEND_S        120
`define GMS_ADDR_CTRL     12'h000
`define GMS_ADDR_STAT     12'h004
`define GMS_ADDR_DATE     12'h008
`define GMS_ADDR_TIME     12'h00c
`define GMS_ADDR_TRIAL    12'h010
`define GMS_TRIAL_RST     16'd300
`define GMS_DAY_RST       8'h01
`define GMS_MON_RST       8'h01
`define GMS_YEAR_RST      16'h2000
`endif

/* File: gms_pkg.sv */
package gms_pkg;
  typedef enum logic [2:0] {
    GMS_K_NONE  = 3'b000, GMS_K_UP = 3'b001, GMS_K_DOWN = 3'b010, GMS_K_LEFT = 3'b011,
    GMS_K_RIGHT = 3'b100, GMS_K_ENTER = 3'b101, GMS_K_EXIT = 3'b110, GMS_K_DIGIT = 3'b111
  } gms_nav_t;
  typedef struct packed {
    gms_nav_t   nav;
    logic [3:0] digit;
    logic       stop_btn;
    logic       start_btn;
    logic       auto_btn;
    logic       trial_btn;
  } gms_keys_t;
  typedef struct packed {
    logic remote_start;
    logic peak_tariff_warn;
    logic peak_tariff_start;
    logic clock_active;
  } gms_starts_t;
  typedef enum logic [1:0] {
    GMS_SCR_DATE = 2'b00, GMS_SCR_OVERVIEW = 2'b01
  } gms_scr_t;
  typedef enum logic [2:0] {
    GMS_M_STOP = 3'b000, GMS_M_MANUAL = 3'b001, GMS_M_AUTO = 3'b010,
    GMS_M_TRIAL_PEND = 3'b011, GMS_M_TRIAL = 3'b100
  } gms_mode_t;
endpackage

/* File: gms_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gms_defines.svh"
module gms_sequencer (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire gms_pkg::gms_keys_t   keys,
  input  wire gms_pkg::gms_starts_t starts,
  input  wire logic              fault,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [11:0]       awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [11:0]       araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   engine_run,
  output logic                   changeover_auto,
  output logic                   water_heater,
  output logic                   lamp_stop,
  output logic                   lamp_auto,
  output logic                   lamp_trial,
  output logic                   msg_valid,
  output logic [2:0]             msg_code,
  output logic                   on_overview,
  output logic [2:0]             cursor_line,
  output logic                   cursor_on_digit,
  output logic [1:0]             cursor_digit,
  output logic [15:0]            trial_left_s
);
  import gms_pkg::*;

  // --- date/time editor ---
  gms_scr_t    scr_ff;
  logic [2:0]  line_ff;
  logic        edit_ff;
  logic [1:0]  dig_ff;
  logic [15:0] fld_ff [5];
  logic [15:0] buf_ff;
  logic [31:0] sec_ff;
  logic [31:0] idle_ff;
  logic [2:0]  msg_ff;
  logic [31:0] msg_t_ff;
  logic        msg_v_ff;
  gms_mode_t   mode_ff;
  logic [31:0] pend_ff;
  logic [15:0] trial_ff;
  logic [15:0] trial_cfg_ff;
  logic        ctrl_manual_ff;
  gms_starts_t starts_q_ff;

  wire in_date   = (scr_ff == GMS_SCR_DATE);
  wire k_enter   = in_date && (keys.nav == GMS_K_ENTER);
  wire k_exit    = in_date && (keys.nav == GMS_K_EXIT);
  wire [1:0] last_dig = (line_ff == 3'd2) ? 2'd3 : 2'd1;
  wire [3:0] shamt = {last_dig - dig_ff, 2'b00};
  wire [15:0] dig_mask = 16'h000f << shamt;
  wire [15:0] buf_digit = (buf_ff & ~dig_mask) | ({12'h000, keys.digit} << shamt);
  // idle and pending timers count whole seconds: a cycle count of minutes overflows 32 bits
  wire sec_tick  = (sec_ff == `GMS_SEC_CYC - 1);
  wire idle_done = (idle_ff >= `GMS_IDLE_S);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_ff  <= GMS_SCR_DATE;
      line_ff <= 3'd0;
      edit_ff <= 1'b0;
      dig_ff  <= 2'd0;
      buf_ff  <= 16'h0000;
      idle_ff <= 32'h0;
      fld_ff[0] <= {8'h00, `GMS_DAY_RST};
      fld_ff[1] <= {8'h00, `GMS_MON_RST};
      fld_ff[2] <= `GMS_YEAR_RST;
      fld_ff[3] <= 16'h0000;
      fld_ff[4] <= 16'h0000;
    end else if (in_date) begin
      idle_ff <= (k_enter || k_exit) ? 32'h0 : idle_ff + {31'h0, sec_tick};
      if (idle_done) begin
        scr_ff <= GMS_SCR_OVERVIEW;
      end else if (!edit_ff) begin
        if (keys.nav == GMS_K_DOWN && line_ff != 3'd4) line_ff <= line_ff + 3'd1;
        if (keys.nav == GMS_K_UP && line_ff != 3'd0) line_ff <= line_ff - 3'd1;
        if (k_enter) begin
          edit_ff <= 1'b1;
          dig_ff  <= 2'd0;
          buf_ff  <= fld_ff[line_ff];
        end
        if (k_exit) scr_ff <= GMS_SCR_OVERVIEW;
      end else begin
        if (keys.nav == GMS_K_DIGIT) begin
          buf_ff <= buf_digit;
          if (dig_ff != last_dig) dig_ff <= dig_ff + 2'd1;
        end
        if (keys.nav == GMS_K_RIGHT && dig_ff != last_dig) dig_ff <= dig_ff + 2'd1;
        if (keys.nav == GMS_K_LEFT && dig_ff != 2'd0) dig_ff <= dig_ff - 2'd1;
        if (k_enter) begin
          fld_ff[line_ff] <= buf_ff;
          edit_ff <= 1'b0;
        end
        if (k_exit) edit_ff <= 1'b0;
      end
    end
  end

  // --- operating modes ---
  wire start_any   = |starts;
  wire start_rise  = |(starts & ~starts_q_ff);
  wire start_fall  = |(~starts & starts_q_ff);
  wire ovw         = (scr_ff == GMS_SCR_OVERVIEW);
  wire pend_done   = (pend_ff >= `GMS_PEND_S);
  wire msg_done    = (msg_t_ff >= `GMS_SEC_CYC * `GMS_MSG_S - 1);
  wire can_auto    = (mode_ff != GMS_M_AUTO);
  wire can_manual  = (mode_ff == GMS_M_STOP) || (mode_ff == GMS_M_AUTO);
  // protection and the stop key are never gated by the screen; starts and the other mode keys are
  logic        nxt_run;
  gms_mode_t   nxt_mode;
  logic [2:0]  nxt_msg;
  logic        nxt_post;

  always_comb begin
    nxt_run  = engine_run;
    nxt_mode = mode_ff;
    nxt_msg  = msg_ff;
    nxt_post = 1'b0;
    if (fault) begin
      nxt_mode = GMS_M_STOP;
      nxt_run  = 1'b0;
    end else if (keys.stop_btn) begin
      nxt_mode = GMS_M_STOP;
      nxt_run  = 1'b0;
      nxt_msg  = 3'd1;
      nxt_post = 1'b1;
    end else if (!ovw) begin
      nxt_run = 1'b0;
    end else begin
      unique case (mode_ff)
        GMS_M_STOP: begin
          nxt_run = 1'b0;
          if (keys.auto_btn) begin
            nxt_mode = GMS_M_AUTO;
            nxt_msg = 3'd2;
            nxt_post = 1'b1;
          end else if (keys.start_btn && can_manual) begin
            nxt_mode = GMS_M_MANUAL;
            nxt_run  = 1'b1;
          end
        end
        GMS_M_MANUAL: begin
          if (keys.auto_btn && can_auto) begin
            nxt_mode = GMS_M_AUTO;
            nxt_msg = 3'd2;
            nxt_post = 1'b1;
          end
        end
        GMS_M_AUTO: begin
          if (keys.start_btn && can_manual) begin
            nxt_mode = GMS_M_MANUAL;
            nxt_run  = 1'b1;
          end else if (keys.trial_btn && !start_any) begin
            nxt_mode = GMS_M_TRIAL_PEND;
          end else if (start_rise) begin
            nxt_run = 1'b1;
            nxt_msg = 3'd3;
            nxt_post = 1'b1;
          end else if (start_fall) begin
            nxt_run = 1'b0;
            nxt_msg = 3'd4;
            nxt_post = 1'b1;
          end
        end
        GMS_M_TRIAL_PEND: begin
          if (keys.trial_btn) begin
            nxt_mode = GMS_M_TRIAL;
            nxt_run  = 1'b1;
          end else if (keys.auto_btn || pend_done) begin
            nxt_mode = GMS_M_AUTO;
            nxt_msg = 3'd2;
            nxt_post = 1'b1;
          end
        end
        GMS_M_TRIAL: begin
          if (start_rise) begin
            nxt_mode = GMS_M_AUTO;
            nxt_msg = 3'd3;
            nxt_post = 1'b1;
          end else if (keys.auto_btn) begin
            nxt_mode = GMS_M_AUTO;
            nxt_msg = 3'd2;
            nxt_post = 1'b1;
          end else if (sec_tick && trial_ff <= 16'd1) begin
            nxt_mode = GMS_M_AUTO;
            nxt_run  = 1'b0;
          end
        end
        default: nxt_mode = GMS_M_STOP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff     <= GMS_M_STOP;
      engine_run  <= 1'b0;
      starts_q_ff <= '0;
      sec_ff      <= 32'h0;
      pend_ff     <= 32'h0;
      trial_ff    <= 16'h0;
      msg_ff      <= 3'd0;
      msg_v_ff    <= 1'b0;
      msg_t_ff    <= 32'h0;
    end else begin
      mode_ff     <= nxt_mode;
      engine_run  <= nxt_run;
      starts_q_ff <= starts;
      sec_ff      <= sec_tick ? 32'h0 : sec_ff + 32'h1;
      pend_ff     <= (mode_ff == GMS_M_TRIAL_PEND) ? pend_ff + {31'h0, sec_tick} : 32'h0;
      if (nxt_mode == GMS_M_TRIAL && mode_ff != GMS_M_TRIAL) trial_ff <= trial_cfg_ff;
      else if (mode_ff == GMS_M_TRIAL && sec_tick && trial_ff != 16'h0)
        trial_ff <= trial_ff - 16'h1;
      if (nxt_post) begin
        msg_ff   <= nxt_msg;
        msg_v_ff <= 1'b1;
        msg_t_ff <= 32'h0;
      end else if (msg_v_ff) begin
        msg_v_ff <= !msg_done;
        msg_t_ff <= msg_t_ff + 32'h1;
      end
    end
  end

  // lamps and outputs from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_stop       <= 1'b1;
      lamp_auto       <= 1'b0;
      lamp_trial      <= 1'b0;
      water_heater    <= 1'b0;
      changeover_auto <= 1'b0;
    end else begin
      lamp_stop       <= (nxt_mode == GMS_M_STOP);
      lamp_auto       <= (nxt_mode == GMS_M_AUTO);
      lamp_trial      <= (nxt_mode == GMS_M_TRIAL) ||
                         ((nxt_mode == GMS_M_TRIAL_PEND) && sec_ff[26]);
      water_heater    <= (nxt_mode != GMS_M_STOP);
      changeover_auto <= (nxt_mode == GMS_M_AUTO);
    end
  end

  assign msg_valid       = msg_v_ff;
  assign msg_code        = msg_ff;
  assign on_overview     = ovw;
  assign cursor_line     = line_ff;
  assign cursor_on_digit = edit_ff;
  assign cursor_digit    = dig_ff;
  assign trial_left_s    = trial_ff;

  // --- axi4-lite slave ---
  logic        aw_ff;
  logic        w_ff;
  logic [11:0] awa_ff;
  logic [31:0] wd_ff;
  logic        wstrb_ok;
  wire         do_wr = aw_ff && w_ff && !bvalid;
  wire         wr_hit = (awa_ff == `GMS_ADDR_TRIAL) || (awa_ff == `GMS_ADDR_CTRL);
  wire [31:0]  rd_mux =
    (araddr == `GMS_ADDR_CTRL)  ? {31'h0, ctrl_manual_ff} :
    (araddr == `GMS_ADDR_STAT)  ? {21'h0, msg_v_ff, ovw, engine_run, 4'h0, 1'b0, mode_ff} :
    (araddr == `GMS_ADDR_DATE)  ? {fld_ff[2], fld_ff[1][7:0], fld_ff[0][7:0]} :
    (araddr == `GMS_ADDR_TIME)  ? {16'h0, fld_ff[3][7:0], fld_ff[4][7:0]} :
    (araddr == `GMS_ADDR_TRIAL) ? {16'h0, trial_cfg_ff} : 32'h0;
  wire         rd_hit = (araddr <= `GMS_ADDR_TRIAL) && (araddr[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0; w_ff <= 1'b0; awa_ff <= 12'h0; wd_ff <= 32'h0;
      bvalid <= 1'b0; bresp <= 2'b00; rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'b00;
      trial_cfg_ff <= `GMS_TRIAL_RST;
      ctrl_manual_ff <= 1'b0;
    end else begin
      if (awvalid && awready) begin aw_ff <= 1'b1; awa_ff <= awaddr; end
      if (wvalid && wready) begin w_ff <= 1'b1; wd_ff <= wdata; end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_hit ? 2'b00 : 2'b10;
        if (awa_ff == `GMS_ADDR_TRIAL && wstrb_ok) trial_cfg_ff <= wd_ff[15:0];
        if (awa_ff == `GMS_ADDR_CTRL) ctrl_manual_ff <= wd_ff[0];
      end else if (bvalid && bready) bvalid <= 1'b0;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_hit ? rd_mux : 32'h0;
        rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid && rready) rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) wstrb_ok <= 1'b0;
    else if (wvalid && wready) wstrb_ok <= &wstrb[1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
    end else begin
      // one write and one read in flight; ready drops once captured
      awready <= !aw_ff && !(awvalid && awready) && !bvalid && !do_wr;
      wready  <= !w_ff && !(wvalid && wready) && !bvalid && !do_wr;
      arready <= !rvalid && !(arvalid && arready);
    end
  end
endmodule
`default_nettype wire

/* File: gms_sequencer_props.sv */
`timescale 1ns/1ps
`default_nettype none
module gms_sequencer_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire gms_pkg::gms_keys_t keys,
  input wire logic               engine_run,
  input wire logic               water_heater,
  input wire logic               lamp_stop,
  input wire logic               msg_valid,
  input wire logic [2:0]         msg_code,
  input wire logic               on_overview,
  input wire logic [2:0]         cursor_line,
  input wire logic               cursor_on_digit,
  input wire logic [1:0]         cursor_digit
);
  import gms_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire line_lvl = !on_overview && !cursor_on_digit;
  wire nav_exit = keys.nav == GMS_K_EXIT;
  property p_boot_stop; $rose(aresetn) |-> lamp_stop && !on_overview && cursor_line == 3'd0;
  endproperty
  a_boot_stop: assert property (p_boot_stop) else $error("boot state wrong");
  property p_line_dn; keys.nav == GMS_K_DOWN && line_lvl && cursor_line < 3'd4
    |=> cursor_line == $past(cursor_line) + 3'd1; endproperty
  a_line_dn: assert property (p_line_dn) else $error("down arrow line");
  property p_dig_adv; keys.nav == GMS_K_DIGIT && cursor_on_digit && cursor_digit == 2'd0
    |=> cursor_on_digit && cursor_digit == 2'd1; endproperty
  a_dig_adv: assert property (p_dig_adv) else $error("digit no advance");
  property p_two_dig; cursor_on_digit && cursor_line != 3'd2 |-> cursor_digit <= 2'd1;
  endproperty
  a_two_dig: assert property (p_two_dig) else $error("digit index too high");
  property p_exit_dig; nav_exit && cursor_on_digit && !on_overview
    |=> !cursor_on_digit && !on_overview; endproperty
  a_exit_dig: assert property (p_exit_dig) else $error("exit on digit");
  property p_exit_line; nav_exit && line_lvl |=> on_overview; endproperty
  a_exit_line: assert property (p_exit_line) else $error("exit at line");
  property p_gate; !on_overview |-> !engine_run; endproperty
  a_gate: assert property (p_gate) else $error("engine ran before overview");
  property p_stop_ack; keys.stop_btn && engine_run
    |-> ##[1:3] (msg_valid && msg_code == 3'd1 && !engine_run); endproperty
  a_stop_ack: assert property (p_stop_ack) else $error("stop press not acted");
  property p_heater; keys.stop_btn |-> ##3 !water_heater; endproperty
  a_heater: assert property (p_heater) else $error("heater on in stop");
endmodule
`default_nettype wire

/* File: gms_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// operator panel: each press is a single-cycle pulse, start inputs are plain levels
module gms_panel_model (
  input  wire logic                 aclk,
  input  wire gms_pkg::gms_keys_t   key_req,
  input  wire logic                 key_go,
  input  wire gms_pkg::gms_starts_t start_req,
  output var  gms_pkg::gms_keys_t   keys,
  output var  gms_pkg::gms_starts_t starts
);
  import gms_pkg::*;
  always_ff @(posedge aclk) begin
    keys   <= key_go ? key_req : '0;
    starts <= start_req;
  end
endmodule
`default_nettype wire

/* File: gms_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gms_defines.svh"
module gms_sequencer_tb;
  import gms_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, fault = 1'b0, key_go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, engine_run, changeover_auto;
  logic        water_heater, lamp_stop, lamp_auto, lamp_trial, msg_valid, on_overview;
  logic        cursor_on_digit;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rd_r, cursor_digit;
  logic [2:0]  msg_code, cursor_line;
  logic [15:0] trial_left_s;
  gms_keys_t   key_req = '0, keys;
  gms_starts_t start_req = '0, starts;
  int          errors = 0, n_compared = 0;
  always #4 aclk = ~aclk;
  gms_sequencer i_gms_sequencer (.*);
  gms_panel_model i_gms_panel_model (.aclk, .key_req, .key_go, .start_req, .keys, .starts);
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 64) begin
      errors++;
      $display("ERROR bus_wait expected answer seen none");
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 64);
    rd_r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 64);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  // b is {stop, start, auto, trial}; the wait covers key and lamp latency
  task automatic kp(input gms_nav_t k, input logic [3:0] d = 4'h0, input logic [3:0] b = 4'h0);
    @(posedge aclk);
    key_req <= '{k, d, b[3], b[2], b[1], b[0]};
    key_go <= 1'b1;
    @(posedge aclk);
    key_go <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic ext(input logic v);
    @(posedge aclk);
    start_req.remote_start <= v;
    repeat (5) @(posedge aclk);
  endtask
  task automatic t_reset;
    chk("reset", {lamp_stop, water_heater, on_overview, cursor_line}, 6'h20);
  endtask
  task automatic t_lines;
    kp(GMS_K_UP);
    chk("line_day", cursor_line, 0);
    repeat (5) kp(GMS_K_DOWN);
    chk("line_minute", cursor_line, 4);
    repeat (4) kp(GMS_K_UP);
    chk("line_back", cursor_line, 0);
  endtask
  task automatic t_digits;
    kp(GMS_K_ENTER);
    chk("digit_first", {cursor_on_digit, cursor_digit}, 3'b100);
    kp(GMS_K_DIGIT, 4'h7);
    chk("digit_adv", cursor_digit, 1);
    kp(GMS_K_LEFT);
    chk("digit_left", cursor_digit, 0);
    kp(GMS_K_RIGHT);
    chk("digit_right", cursor_digit, 1);
    kp(GMS_K_EXIT);
    rd(`GMS_ADDR_DATE);
    chk("day_kept", {cursor_on_digit, rd_v[7:0]}, 9'h001);
    kp(GMS_K_ENTER);
    kp(GMS_K_DIGIT, 4'h2);
    kp(GMS_K_DIGIT, 4'h5);
    kp(GMS_K_ENTER);
    rd(`GMS_ADDR_DATE);
    chk("day_commit", {cursor_on_digit, rd_v[7:0]}, 9'h025);
    repeat (2) kp(GMS_K_DOWN);
    kp(GMS_K_ENTER);
    repeat (3) kp(GMS_K_RIGHT);
    chk("year_digit", cursor_digit, 3);
    kp(GMS_K_EXIT);
  endtask
  task automatic t_gate;
    kp(GMS_K_NONE, 4'h0, 4'h4);
    chk("start_blocked", engine_run, 0);
    kp(GMS_K_EXIT);
    rd(`GMS_ADDR_DATE);
    chk("overview_date", {on_overview, rd_v}, 33'h1_2000_0125);
  endtask
  task automatic t_stop_manual;
    ext(1'b1);
    chk("stop_mode", {engine_run, lamp_stop, water_heater}, 3'b010);
    ext(1'b0);
    kp(GMS_K_NONE, 4'h0, 4'h4);
    rd(`GMS_ADDR_STAT);
    chk("manual_run", {engine_run, rd_v[2:0]}, 4'h9);
    kp(GMS_K_NONE, 4'h0, 4'h8);
    chk("stop_ack", {engine_run, msg_valid, msg_code}, 5'b01001);
  endtask
  task automatic t_auto;
    kp(GMS_K_NONE, 4'h0, 4'h2);
    chk("auto_sel", {lamp_auto, changeover_auto, msg_code}, 5'b11010);
    ext(1'b1);
    chk("auto_start", {engine_run, msg_code}, 4'hb);
    kp(GMS_K_NONE, 4'h0, 4'h1);
    rd(`GMS_ADDR_STAT);
    chk("trial_refused", rd_v[2:0], 2);
    ext(1'b0);
    chk("auto_shutdown", msg_code, 4);
  endtask
  task automatic t_trial;
    wr(`GMS_ADDR_TRIAL, 32'h5);
    chk("wr_resp", rd_r, 0);
    kp(GMS_K_NONE, 4'h0, 4'h1);
    rd(`GMS_ADDR_STAT);
    chk("trial_pend", rd_v[2:0], 3);
    kp(GMS_K_NONE, 4'h0, 4'h1);
    rd(`GMS_ADDR_STAT);
    chk("trial_run", {rd_v[2:0], lamp_trial, changeover_auto, trial_left_s}, 21'h120005);
    ext(1'b1);
    rd(`GMS_ADDR_STAT);
    chk("trial_abandon", {rd_v[2:0], changeover_auto}, 4'h5);
    ext(1'b0);
    rd(12'h100);
    chk("unmapped", {rd_r, rd_v}, 34'h2_0000_0000);
  endtask
  task automatic t_fault;
    ext(1'b1);
    @(posedge aclk);
    fault <= 1'b1;
    @(posedge aclk);
    fault <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(`GMS_ADDR_STAT);
    chk("fault_stop", {engine_run, rd_v[2:0]}, 4'h0);
    ext(1'b0);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_lines();
    t_digits();
    t_gate();
    t_stop_manual();
    t_auto();
    t_trial();
    t_fault();
    end_sim();
  end
endmodule
bind gms_sequencer gms_sequencer_props i_gms_sequencer_props (.*);
`default_nettype wire
